// *** cies_core.sv ***
// Purpose: Executes the watchdog, call, complement, clear, decrement subset
// Assumes: One instruction presented per cycle with i_instr_valid
// Notes: File register read is combinational from the outside data path
//
// Functional notes
// - The watchdog clear loads the watchdog counter with zero.
// - The watchdog clear also zeroes the watchdog prescaler.
// - The watchdog clear sets timeout and power-down status bits, nothing else.
// - A call pushes the address of the next instruction onto the return stack.
// - A call loads PC 10..0 from the immediate and PC 12..11 from page latch 4..3.
// - A call takes two cycles and leaves the status flags alone.
// - Complement inverts the file register and updates the zero flag.
// - Destination bit 0 writes the accumulator, 1 writes the file register.
// - Clear file writes zero to the file register and sets the zero flag.
// - Clear accumulator writes zero to the accumulator and sets the zero flag.
// - Decrement subtracts one, writes the destination and updates the zero flag.
// - Decrement skip subtracts one, writes the destination, keeps all flags.
// - A zero decrement skip result replaces the next instruction by a no-operation.
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module cies_core import cies_pkg::*; #(
    parameter int STACK_DEPTH = CIES_STACK_DEPTH
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_instr_valid,
    input wire logic [CIES_INSTR_W-1:0] i_instr,
    input wire logic [CIES_DATA_W-1:0] i_file_rdata,
    input wire logic [CIES_DATA_W-1:0] i_program_page_latch,
    output logic [CIES_ADDR_W-1:0] o_file_addr,
    output logic o_file_we,
    output logic [CIES_DATA_W-1:0] o_file_wdata,
    output logic [CIES_DATA_W-1:0] o_accum,
    output logic o_zero_flag,
    output logic [CIES_PC_W-1:0] o_pc,
    output logic [CIES_PC_W-1:0] o_return_stack_top,
    output logic o_watchdog_clear,
    output logic o_prescaler_clear,
    output logic o_timeout_status_bit,
    output logic o_powerdown_status_bit,
    output logic o_busy
);
    // ==========================================================
    // State
    typedef struct packed {
        cies_state_t fsm;
        logic [CIES_DATA_W-1:0] accum;
        logic zero;
        logic [CIES_PC_W-1:0] pc;
        logic timeout;
        logic powerdown;
        logic wdt_clr;
        logic psc_clr;
        logic file_we;
        logic [CIES_ADDR_W-1:0] faddr;
        logic [CIES_DATA_W-1:0] fwdata;
    } cies_core_state_t;

    cies_core_state_t st;
    cies_core_state_t next_st;
    logic push;
    logic [CIES_PC_W-1:0] push_data;

    // ==========================================================
    // Decode
    logic is_wdt_clr;
    logic is_clr_acc;
    logic is_clr_file;
    logic is_dec;
    logic is_comp;
    logic is_dec_skip;
    logic is_call;
    logic dest_file;
    logic [CIES_DATA_W-1:0] dec_val;
    logic [CIES_DATA_W-1:0] comp_val;

    assign is_wdt_clr = (i_instr == CIES_OP_WDT_CLR);
    assign is_clr_acc = (i_instr[13:7] == CIES_OP_CLR_ACC[13:7]);
    assign is_clr_file = (i_instr[13:8] == CIES_OP_CLR_FILE) && i_instr[7];
    assign is_dec = (i_instr[13:8] == CIES_OP_DEC);
    assign is_comp = (i_instr[13:8] == CIES_OP_COMP);
    assign is_dec_skip = (i_instr[13:8] == CIES_OP_DEC_SKIP);
    assign is_call = (i_instr[13:11] == CIES_OP_CALL);
    assign dest_file = i_instr[7];
    assign dec_val = i_file_rdata - CIES_DEC_STEP;
    assign comp_val = ~i_file_rdata;
    assign o_file_addr = i_instr[CIES_ADDR_W-1:0];

    // ==========================================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.wdt_clr = 1'b0;
        next_st.psc_clr = 1'b0;
        next_st.file_we = 1'b0;
        push = 1'b0;
        push_data = st.pc + CIES_PC_STEP;
        if (st.fsm == CIES_FLUSH) begin
            next_st.fsm = CIES_EXEC;
        end else if (i_instr_valid) begin
            next_st.pc = st.pc + CIES_PC_STEP;
            next_st.faddr = i_instr[CIES_ADDR_W-1:0];
            if (is_wdt_clr) begin
                next_st.wdt_clr = 1'b1;
                next_st.psc_clr = 1'b1;
                next_st.timeout = 1'b1;
                next_st.powerdown = 1'b1;
            end else if (is_call) begin
                push = 1'b1;
                next_st.pc = {i_program_page_latch[CIES_LATCH_HI:CIES_LATCH_LO],
                    i_instr[10:0]};
                next_st.fsm = CIES_FLUSH;
            end else if (is_clr_acc) begin
                next_st.accum = CIES_ZERO_BYTE;
                next_st.zero = 1'b1;
            end else if (is_clr_file) begin
                next_st.file_we = 1'b1;
                next_st.fwdata = CIES_ZERO_BYTE;
                next_st.zero = 1'b1;
            end else if (is_comp || is_dec || is_dec_skip) begin
                if (dest_file) begin
                    next_st.file_we = 1'b1;
                    next_st.fwdata = is_comp ? comp_val : dec_val;
                end else begin
                    next_st.accum = is_comp ? comp_val : dec_val;
                end
                if (is_comp) begin
                    next_st.zero = (comp_val == CIES_ZERO_BYTE);
                end else if (is_dec) begin
                    next_st.zero = (dec_val == CIES_ZERO_BYTE);
                end
                if (is_dec_skip && dec_val == CIES_ZERO_BYTE) begin
                    next_st.fsm = CIES_FLUSH;
                    next_st.pc = st.pc + CIES_PC_STEP + CIES_PC_STEP;
                end
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st <= '{fsm: CIES_EXEC, accum: CIES_ACC_RESET, zero: 1'b0,
                pc: CIES_PC_RESET, timeout: 1'b1, powerdown: 1'b1, wdt_clr: 1'b0,
                psc_clr: 1'b0, file_we: 1'b0, faddr: '0, fwdata: CIES_ZERO_BYTE};
        end else begin
            st <= next_st;
        end
    end

    cies_stack #(.DEPTH(STACK_DEPTH), .W(CIES_PC_W)) u_stack (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_push(push),
        .i_data(push_data),
        .o_top(o_return_stack_top)
    );

    assign o_file_we = st.file_we;
    assign o_file_wdata = st.fwdata;
    assign o_accum = st.accum;
    assign o_zero_flag = st.zero;
    assign o_pc = st.pc;
    assign o_watchdog_clear = st.wdt_clr;
    assign o_prescaler_clear = st.psc_clr;
    assign o_timeout_status_bit = st.timeout;
    assign o_powerdown_status_bit = st.powerdown;
    assign o_busy = (st.fsm == CIES_FLUSH);

    // ==========================================================
    // Assertions
    logic exec;
    assign exec = i_instr_valid && !o_busy;

    a_wdt_clear_pulse: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_wdt_clr |=> o_watchdog_clear && o_prescaler_clear)
        else $error("watchdog clear missing");
    a_wdt_status_set: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_wdt_clr |=> o_timeout_status_bit && o_powerdown_status_bit
            && $stable(o_zero_flag))
        else $error("status bits not set");
    a_call_target: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_call |=> o_pc == {$past(i_program_page_latch[4:3]), $past(i_instr[10:0])})
        else $error("call target wrong");
    a_call_push: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_call |=> ##1 o_return_stack_top == $past(o_pc, 2) + 13'h0001)
        else $error("return address wrong");
    a_call_two_cyc: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_call |=> o_busy ##1 !o_busy)
        else $error("call not two cycles");
    a_clr_acc_zero: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_clr_acc |=> o_accum == 8'h00 && o_zero_flag)
        else $error("clear accumulator failed");
    a_clr_file_zero: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_clr_file |=> o_file_we && o_file_wdata == 8'h00 && o_zero_flag)
        else $error("clear file failed");
    a_comp_result: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_comp && !dest_file |=> o_accum == ~$past(i_file_rdata)
            && o_zero_flag == ($past(i_file_rdata) == 8'hff))
        else $error("complement wrong");
    a_dec_dest_file: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_dec && dest_file |=> o_file_we && $stable(o_accum)
            && o_file_wdata == $past(i_file_rdata) - 8'h01)
        else $error("decrement destination wrong");
    a_dec_zero: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_dec |=> o_zero_flag == ($past(i_file_rdata) == 8'h01))
        else $error("decrement zero flag wrong");
    a_skip_flags: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_dec_skip |=> $stable(o_zero_flag))
        else $error("skip changed flags");
    a_skip_nop: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_dec_skip && i_file_rdata == 8'h01 |=> o_busy ##1 !o_busy)
        else $error("skip did not flush");
    a_single_cycle: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && !is_call && !(is_dec_skip && i_file_rdata == 8'h01) |=> !o_busy)
        else $error("unexpected stall");


    a_wdt_pulse_cause: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        o_watchdog_clear |-> $past(exec && is_wdt_clr))
        else $error("stray watchdog clear");
    a_psc_pulse_cause: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        o_prescaler_clear |-> $past(exec && is_wdt_clr))
        else $error("stray prescaler clear");
    a_psc_with_wdt: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_wdt_clr |=> o_prescaler_clear)
        else $error("prescaler clear missing");
    a_wdt_keeps_data: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_wdt_clr |=> $stable(o_accum) && !o_file_we)
        else $error("watchdog clear touched data");
    a_status_hold: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        !(exec && is_wdt_clr) |=> $stable(o_timeout_status_bit)
            && $stable(o_powerdown_status_bit))
        else $error("status bits changed");

    a_call_flags: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_call |=> $stable(o_zero_flag) && $stable(o_accum))
        else $error("call changed flags");
    a_call_no_write: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_call |=> !o_file_we)
        else $error("call wrote a file register");

    a_flush_pc_hold: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        o_busy |=> $stable(o_pc) && !o_file_we)
        else $error("discarded instruction ran");
    a_flush_data_hold: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        o_busy |=> $stable(o_accum) && $stable(o_zero_flag))
        else $error("discarded instruction changed data");
    a_skip_pc: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_dec_skip && i_file_rdata == 8'h01 |=> o_pc == $past(o_pc) + 13'h0002)
        else $error("skip pc wrong");
    a_skip_go_on: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_dec_skip && i_file_rdata != 8'h01 |=> !o_busy
            && o_pc == $past(o_pc) + 13'h0001)
        else $error("nonzero skip stalled");

    a_comp_file: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_comp && dest_file |=> o_file_we && $stable(o_accum)
            && o_file_wdata == ~$past(i_file_rdata))
        else $error("complement to file wrong");
    a_dec_acc: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_dec && !dest_file |=> !o_file_we
            && o_accum == $past(i_file_rdata) - 8'h01)
        else $error("decrement to accumulator wrong");
    a_write_cause: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        o_file_we |-> $past(exec && (is_clr_file
            || ((is_comp || is_dec || is_dec_skip) && dest_file))))
        else $error("stray file write");
    a_skip_acc: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_dec_skip && !dest_file |=> !o_file_we
            && o_accum == $past(i_file_rdata) - 8'h01)
        else $error("skip to accumulator wrong");
    a_skip_file: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_dec_skip && dest_file |=> o_file_we
            && o_file_wdata == $past(i_file_rdata) - 8'h01)
        else $error("skip to file wrong");

    a_clr_file_acc: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_clr_file |=> $stable(o_accum))
        else $error("clear file touched accumulator");
    a_clr_acc_nowr: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_clr_acc |=> !o_file_we)
        else $error("clear accumulator wrote file");

    a_zero_from_file: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && (is_comp || is_dec) && dest_file |=> o_zero_flag == (o_file_wdata == 8'h00))
        else $error("zero flag mismatch on file result");
    a_zero_from_acc: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && (is_comp || is_dec) && !dest_file |=> o_zero_flag == (o_accum == 8'h00))
        else $error("zero flag mismatch on accumulator");
    a_comp_zero: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_comp |=> o_zero_flag == ($past(i_file_rdata) == 8'hff))
        else $error("complement zero flag wrong");

    a_single_pc: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && !is_call && !(is_dec_skip && i_file_rdata == 8'h01)
            |=> o_pc == $past(o_pc) + 13'h0001)
        else $error("pc step wrong");
    a_idle_pc_hold: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        !i_instr_valid && !o_busy |=> $stable(o_pc))
        else $error("pc moved while idle");

    c_call: cover property (@(posedge i_core_clk) disable iff (!i_nrst) exec && is_call);
    c_comp_file: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_comp && dest_file);
    c_skip_go: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_dec_skip && i_file_rdata != 8'h01);
    c_skip: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
        exec && is_dec_skip && i_file_rdata == 8'h01);
    c_wdt: cover property (@(posedge i_core_clk) disable iff (!i_nrst) exec && is_wdt_clr);
endmodule

// *** cies_pkg.sv ***
// Purpose: Shared constants for the instruction execution subset
// Assumes: 14-bit instruction words, 13-bit program counter
// Notes: Opcode values are the standard encodings of this core family
package cies_pkg;
    // ==========================================================
    // Widths
    localparam int CIES_PC_W = 13;
    localparam int CIES_DATA_W = 8;
    localparam int CIES_ADDR_W = 7;
    localparam int CIES_INSTR_W = 14;
    localparam int CIES_STACK_DEPTH = 8;
    // ==========================================================
    // Instruction encodings
    localparam logic [13:0] CIES_OP_WDT_CLR = 14'h0064;
    localparam logic [13:0] CIES_OP_CLR_ACC = 14'h0100;
    localparam logic [5:0] CIES_OP_CLR_FILE = 6'h01;
    localparam logic [5:0] CIES_OP_DEC = 6'h03;
    localparam logic [5:0] CIES_OP_COMP = 6'h09;
    localparam logic [5:0] CIES_OP_DEC_SKIP = 6'h0b;
    localparam logic [2:0] CIES_OP_CALL = 3'h4;
    // ==========================================================
    // Reset values and constants
    localparam logic [7:0] CIES_ZERO_BYTE = 8'h00;
    localparam logic [7:0] CIES_ACC_RESET = 8'h00;
    localparam logic [12:0] CIES_PC_RESET = 13'h0000;
    localparam logic [12:0] CIES_PC_STEP = 13'h0001;
    localparam logic [7:0] CIES_DEC_STEP = 8'h01;
    localparam int CIES_LATCH_LO = 3;
    localparam int CIES_LATCH_HI = 4;
    typedef enum logic [0:0] {
        CIES_EXEC = 1'b0,
        CIES_FLUSH = 1'b1
    } cies_state_t;
endpackage

// *** cies_stack.sv ***
// Purpose: Return stack memory, circular, registered top output
// Assumes: Push only in this subset; overflow wraps silently
// Notes: Read data comes from a register
`timescale 1ns/1ps
module cies_stack import cies_pkg::*; #(
    parameter int DEPTH = CIES_STACK_DEPTH,
    parameter int W = CIES_PC_W
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_push,
    input wire logic [W-1:0] i_data,
    output logic [W-1:0] o_top
);
    typedef struct packed {
        logic [$clog2(DEPTH)-1:0] ptr;
        logic [W-1:0] top;
    } cies_stk_t;
    logic [W-1:0] mem [DEPTH];
    cies_stk_t st;
    cies_stk_t next_st;
    always_comb begin
        next_st = st;
        if (i_push) begin
            next_st.ptr = st.ptr + 1'b1;
            next_st.top = i_data;
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (i_push) begin
            mem[st.ptr] <= i_data;
        end
    end
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign o_top = st.top;
endmodule

// *** test_core_instr_exec_subset.sv ***
// Purpose: Self-checking bench for the instruction execution subset
// Assumes: Results show right after the taking edge and are checked at the next falling edge
// Notes: The bench plays the file register read path and the page latch
`timescale 1ns/1ps
module test_core_instr_exec_subset import cies_pkg::*;;
    logic i_core_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_instr_valid = 1'b0;
    logic [13:0] i_instr = 14'h0000;
    logic [7:0] i_file_rdata = 8'h00;
    logic [7:0] i_program_page_latch = 8'hf7;
    logic [6:0] o_file_addr;
    logic o_file_we;
    logic [7:0] o_file_wdata;
    logic [7:0] o_accum;
    logic o_zero_flag;
    logic [12:0] o_pc;
    logic [12:0] o_return_stack_top;
    logic o_watchdog_clear;
    logic o_prescaler_clear;
    logic o_timeout_status_bit;
    logic o_powerdown_status_bit;
    logic o_busy;
    logic [12:0] ep = 13'h0000;
    int failures = 0;
    int samples_checked = 0;
    // ==========================================================
    // Clock and design
    always #50 i_core_clk = ~i_core_clk;
    cies_core cies_core_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
        .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_file_rdata(i_file_rdata),
        .i_program_page_latch(i_program_page_latch), .o_file_addr(o_file_addr),
        .o_file_we(o_file_we), .o_file_wdata(o_file_wdata), .o_accum(o_accum),
        .o_zero_flag(o_zero_flag), .o_pc(o_pc), .o_return_stack_top(o_return_stack_top),
        .o_watchdog_clear(o_watchdog_clear), .o_prescaler_clear(o_prescaler_clear),
        .o_timeout_status_bit(o_timeout_status_bit),
        .o_powerdown_status_bit(o_powerdown_status_bit), .o_busy(o_busy));
    // ==========================================================
    // Helpers
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic op(input logic [13:0] ins, input logic [7:0] rd);
        @(posedge i_core_clk);
        i_instr <= ins;
        i_file_rdata <= rd;
        i_instr_valid <= 1'b1;
        @(posedge i_core_clk);
        i_instr_valid <= 1'b0;
        @(negedge i_core_clk);
        ep = ep + 13'h0001;
    endtask
    task automatic st(input logic [7:0] acc, input logic z, input logic we);
        chk("accum", acc, o_accum);
        chk("zero", z, o_zero_flag);
        chk("we", we, o_file_we);
        chk("pc", ep, o_pc);
    endtask
    task automatic report_and_stop;
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset;
        st(8'h00, 1'b0, 1'b0);
        chk("busy", 1'b0, o_busy);
        chk("timeout", 1'b1, o_timeout_status_bit);
        chk("powerdown", 1'b1, o_powerdown_status_bit);
    endtask
    task automatic t_arith;
        op({CIES_OP_COMP, 1'b0, 7'h11}, 8'h5a);
        st(8'ha5, 1'b0, 1'b0);
        op({CIES_OP_COMP, 1'b1, 7'h11}, 8'hff);
        st(8'ha5, 1'b1, 1'b1);
        chk("wdata", 8'h00, o_file_wdata);
        op({CIES_OP_DEC, 1'b0, 7'h05}, 8'h00);
        st(8'hff, 1'b0, 1'b0);
        op(CIES_OP_CLR_ACC, 8'h5a);
        st(8'h00, 1'b1, 1'b0);
        op({CIES_OP_DEC, 1'b1, 7'h05}, 8'h01);
        st(8'h00, 1'b1, 1'b1);
        chk("wdata", 8'h00, o_file_wdata);
        op({CIES_OP_DEC, 1'b0, 7'h05}, 8'h81);
        st(8'h80, 1'b0, 1'b0);
    endtask
    task automatic t_clear_file;
        op({CIES_OP_CLR_FILE, 1'b1, 7'h20}, 8'h5a);
        st(8'h80, 1'b1, 1'b1);
        chk("wdata", 8'h00, o_file_wdata);
        chk("addr", 7'h20, o_file_addr);
        op({CIES_OP_DEC, 1'b0, 7'h05}, 8'h81);
    endtask
    task automatic t_watchdog;
        op(CIES_OP_WDT_CLR, 8'h00);
        st(8'h80, 1'b0, 1'b0);
        chk("wdt_clr", 1'b1, o_watchdog_clear);
        chk("pre_clr", 1'b1, o_prescaler_clear);
        chk("timeout", 1'b1, o_timeout_status_bit);
        chk("powerdown", 1'b1, o_powerdown_status_bit);
        @(negedge i_core_clk);
        chk("wdt_clr", 1'b0, o_watchdog_clear);
        op(14'h0700, 8'h33);
        st(8'h80, 1'b0, 1'b0);
    endtask
    task automatic t_call;
        logic [12:0] ret;
        ret = ep + 13'h0001;
        @(posedge i_core_clk);
        i_instr <= {CIES_OP_CALL, 11'h2a5};
        i_instr_valid <= 1'b1;
        @(posedge i_core_clk);
        i_instr <= CIES_OP_CLR_ACC;
        @(negedge i_core_clk);
        ep = {2'b10, 11'h2a5};
        chk("pc", ep, o_pc);
        chk("stack", ret, o_return_stack_top);
        chk("busy", 1'b1, o_busy);
        chk("zero", 1'b0, o_zero_flag);
        @(posedge i_core_clk);
        i_instr_valid <= 1'b0;
        @(negedge i_core_clk);
        chk("busy", 1'b0, o_busy);
        st(8'h80, 1'b0, 1'b0);
    endtask
    task automatic t_skip;
        op({CIES_OP_DEC_SKIP, 1'b1, 7'h30}, 8'h02);
        st(8'h80, 1'b0, 1'b1);
        chk("wdata", 8'h01, o_file_wdata);
        chk("busy", 1'b0, o_busy);
        op({CIES_OP_DEC_SKIP, 1'b0, 7'h30}, 8'h01);
        ep = ep + 13'h0001;
        st(8'h00, 1'b0, 1'b0);
        chk("busy", 1'b1, o_busy);
        @(negedge i_core_clk);
        chk("busy", 1'b0, o_busy);
        chk("pc", ep, o_pc);
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (3) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        @(negedge i_core_clk);
        t_reset();
        t_arith();
        t_clear_file();
        t_watchdog();
        t_call();
        t_skip();
        report_and_stop();
    end
    initial begin
        #200000;
        failures++;
        report_and_stop();
    end
endmodule
